// >>> logic/serial_port_cfg.svh
// serial port constants: register offsets, field positions, reset values
// assumes inclusion by bare name from both ends; the package does not include it
`ifndef SERIAL_PORT_CFG_SVH
`define SERIAL_PORT_CFG_SVH

// register byte offsets on apb
`define OFS_CONTROL 8'h00
`define OFS_BUFFER 8'h04
`define OFS_STATUS 8'h08
`define OFS_BAUD 8'h0c

// control register fields
`define CTL_ACK_EN_BIT 0
`define CTL_ACK_DATA_BIT 1
`define CTL_POLARITY_BIT 2
`define CTL_HOLD_BIT 3
`define CTL_SLAVE_BIT 4

// status register fields
`define STA_BUSY_BIT 0
`define STA_WRITE_COLLISION_FLAG_BIT 1
`define STA_DONE_BIT 2

// reset values and last bit index of a byte
`define BAUD_RESET 8'h04
`define SELECT_NONE 2'b11
`define BITS_PER_BYTE 3'h7

`endif

// >>> logic/serial_port_pkg.sv
// types shared by both ends of the serial link
// assumes the cfg header on the include path
package serial_port_pkg;
   // port sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SPI_LEAD = 3'b001,
      ST_SPI_TRAIL = 3'b010,
      ST_ACK_LOW = 3'b011,
      ST_ACK_WAIT = 3'b100,
      ST_ACK_HIGH = 3'b101
   } port_state_t;
endpackage

// >>> logic/serial_link_if.sv
// link between the serial port (master) and a far end (spi slave / i2c target)
// assumes one clock for both ends; open-drain lines resolved here
`timescale 1ns/100ps
interface serial_link_if;
   logic serial_clock_pin; // spi clock from master
   logic serial_out_pin; // master data out, slave data in
   logic [1:0] slave_select_pin_n; // one select per slave, low active
   logic slave_out_o; // slave data out value
   logic slave_out_oe; // slave drives its data line
   logic serial_in_pin; // master data in
   logic dev_scl_oe; // master pulls scl low
   logic dev_sda_oe; // master pulls sda low
   logic far_scl_oe; // target stretches scl low
   logic scl_level; // resolved scl
   logic sda_level; // resolved sda

   // undriven data line idles high
   assign serial_in_pin = slave_out_oe ? slave_out_o : 1'b1;
   // open-drain wired-and with pull-ups
   assign scl_level = ~(dev_scl_oe | far_scl_oe);
   assign sda_level = ~dev_sda_oe;

   modport dev (output serial_clock_pin, serial_out_pin, slave_select_pin_n, dev_scl_oe, dev_sda_oe,
                input serial_in_pin, scl_level);
   modport far (input serial_clock_pin, serial_out_pin, slave_select_pin_n, scl_level, sda_level,
                output slave_out_o, slave_out_oe, far_scl_oe);
endinterface

// >>> logic/serial_far_end.sv
// far end of the link: spi slave plus an i2c target that may stretch scl
// assumes the master drives all link inputs from flops on the same clk
`timescale 1ns/100ps
`include "serial_port_cfg.svh"
module serial_far_end import serial_port_pkg::*; #(
   parameter int SELECT_INDEX = 0
) (
   input wire logic clk,
   input wire logic reset,
   serial_link_if.far link,
   input wire logic [7:0] tx_byte,
   input wire logic clock_polarity,
   input wire logic stretch_hold,
   output logic [7:0] rx_byte,
   output logic rx_valid,
   output logic [7:0] ack_value,
   output logic ack_valid
);
   logic [7:0] shift_q, shift_d; // slave shift register
   logic rx_bit_q, rx_bit_d; // bit caught on leading edge
   logic [2:0] bit_q, bit_d; // bits done in this byte
   logic sclk_q, sclk_d; // last clock level seen
   logic sel_q, sel_d; // selected last cycle
   logic oe_q, oe_d; // data line enable
   logic [7:0] rx_q, rx_d; // received byte
   logic rxv_q, rxv_d; // byte done pulse
   logic scl_prev_q, scl_prev_d; // last scl level
   logic stretch_q, stretch_d; // scl pulled low
   logic [7:0] ackv_q, ackv_d; // sda sampled at scl rise, low bit
   logic ackp_q, ackp_d; // sample pulse
   logic sel; // select asserted now
   logic lead; // clock leaves idle level
   logic trail; // clock returns to idle level

   // next values for the slave and target
   always_comb begin
      sel = ~link.slave_select_pin_n[SELECT_INDEX];
      lead = (link.serial_clock_pin != sclk_q) && (link.serial_clock_pin != clock_polarity);
      trail = (link.serial_clock_pin != sclk_q) && (link.serial_clock_pin == clock_polarity);
      shift_d = shift_q;
      rx_bit_d = rx_bit_q;
      bit_d = bit_q;
      rx_d = rx_q;
      rxv_d = 1'b0;
      sclk_d = link.serial_clock_pin;
      sel_d = sel;
      oe_d = sel;
      if (!sel) begin
         bit_d = 3'h0; // unselected: clock and data ignored
      end else if (!sel_q) begin
         shift_d = tx_byte; // byte loaded when selected
         bit_d = 3'h0;
      end else if (lead) begin
         rx_bit_d = link.serial_out_pin; // capture on opposite edge
      end else if (trail) begin
         shift_d = {shift_q[6:0], rx_bit_q}; // msb out, lsb
         bit_d = bit_q + 3'h1;
         if (bit_q == `BITS_PER_BYTE) begin
            rx_d = {shift_q[6:0], rx_bit_q}; // full swap after eight bits
            rxv_d = 1'b1;
            shift_d = tx_byte; // next byte of a longer transfer
         end
      end
      // i2c target: stretch and sample sda on scl rise
      scl_prev_d = link.scl_level;
      stretch_d = stretch_hold;
      ackv_d = ackv_q;
      ackp_d = 1'b0;
      if (link.scl_level && !scl_prev_q) begin
         ackv_d = {7'h00, link.sda_level};
         ackp_d = 1'b1;
      end
   end

   // register all state
   always_ff @(posedge clk) begin
      if (reset) begin
         shift_q <= 8'h00;
         rx_bit_q <= 1'b0;
         bit_q <= 3'h0;
         sclk_q <= 1'b0;
         sel_q <= 1'b0;
         oe_q <= 1'b0;
         rx_q <= 8'h00;
         rxv_q <= 1'b0;
         scl_prev_q <= 1'b1;
         stretch_q <= 1'b0;
         ackv_q <= 8'h00;
         ackp_q <= 1'b0;
      end else begin
         shift_q <= shift_d;
         rx_bit_q <= rx_bit_d;
         bit_q <= bit_d;
         sclk_q <= sclk_d;
         sel_q <= sel_d;
         oe_q <= oe_d;
         rx_q <= rx_d;
         rxv_q <= rxv_d;
         scl_prev_q <= scl_prev_d;
         stretch_q <= stretch_d;
         ackv_q <= ackv_d;
         ackp_q <= ackp_d;
      end
   end

   // link and user outputs straight from flops
   assign link.slave_out_o = shift_q[7];
   assign link.slave_out_oe = oe_q;
   assign link.far_scl_oe = stretch_q;
   assign rx_byte = rx_q;
   assign rx_valid = rxv_q;
   assign ack_value = ackv_q;
   assign ack_valid = ackp_q;
endmodule

// >>> logic/sync_serial_port.sv
// synchronous serial port: spi master exchange and i2c acknowledge sequence
// assumes apb master on clk; far end joined through serial_link_if
`timescale 1ns/100ps
`include "serial_port_cfg.svh"
// How it works
// - four spi signals: clock, out, in, select
// - eight-bit shift, msb out, lsb in
// - drive one clock edge, capture the other
// - one bit each way per clock
// - eight bits fully swap both registers
// - master clocks; both ends share polarity
// - reload and repeat; any length allowed
// - done: stop clock, deselect slave unless hold is set
// - only one slave selected at once
// - unselected slave ignores link, drives nothing
// - ack enable pulls scl low, shows bit
// - software sets ack bit before enabling
// - one baud period, then release scl
// - wait scl high, one period, low
// - end: clear enable, stop baud, idle
// - buffer write while busy sets collision
module sync_serial_port import serial_port_pkg::*; (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   serial_link_if.dev link
);
   port_state_t state_q, state_d; // sequencer state
   logic [7:0] baud_q, baud_d; // baud reload value
   logic [7:0] cnt_q, cnt_d; // baud down counter
   logic [7:0] shift_q, shift_d; // spi shift register
   logic [7:0] buffer_q, buffer_d; // last received byte
   logic [2:0] bit_q, bit_d; // bits done in byte
   logic rx_bit_q, rx_bit_d; // bit caught on leading edge
   logic sclk_q, sclk_d; // spi clock out
   logic mosi_q, mosi_d; // spi data out
   logic [1:0] ss_n_q, ss_n_d; // slave selects
   logic scl_oe_q, scl_oe_d; // scl pulled low
   logic sda_oe_q, sda_oe_d; // sda pulled low
   logic ack_en_q, ack_en_d; // ack sequence enable
   logic ack_dt_q, ack_dt_d; // ack data value
   logic pol_q, pol_d; // spi clock idle level
   logic hold_q, hold_d; // keep slave selected between bytes
   logic sidx_q, sidx_d; // which slave to select
   logic write_collision_flag_q, write_collision_flag_d; // write collision flag
   logic done_q, done_d; // byte done flag
   logic [31:0] rdata_q, rdata_d; // apb read data
   logic rdy_q, rdy_d; // apb ready
   logic err_q, err_d; // apb error
   logic setup; // apb setup cycle
   logic wr; // apb write takes effect
   logic mapped; // address hits a register
   logic write_collision_flag_set; // collision event this cycle
   logic done_set; // byte finished this cycle
   logic cnt_zero; // baud period elapsed

   // next values for bus slave and sequencer
   always_comb begin
      setup = psel && !penable;
      wr = psel && penable && rdy_q && pwrite;
      mapped = (paddr == `OFS_CONTROL) || (paddr == `OFS_BUFFER) ||
               (paddr == `OFS_STATUS) || (paddr == `OFS_BAUD);
      cnt_zero = (cnt_q == 8'h00);
      write_collision_flag_set = 1'b0;
      done_set = 1'b0;
      state_d = state_q;
      baud_d = baud_q;
      cnt_d = cnt_q;
      shift_d = shift_q;
      buffer_d = buffer_q;
      bit_d = bit_q;
      rx_bit_d = rx_bit_q;
      sclk_d = sclk_q;
      mosi_d = mosi_q;
      ss_n_d = ss_n_q;
      scl_oe_d = scl_oe_q;
      sda_oe_d = sda_oe_q;
      ack_en_d = ack_en_q;
      ack_dt_d = ack_dt_q;
      pol_d = pol_q;
      hold_d = hold_q;
      sidx_d = sidx_q;
      write_collision_flag_d = write_collision_flag_q;
      done_d = done_q;
      // answer in the cycle after setup
      rdy_d = setup;
      err_d = setup && !mapped;
      rdata_d = 32'h0000_0000;
      if (setup) begin
         unique case (paddr)
            `OFS_CONTROL: rdata_d = {27'h0, sidx_q, hold_q, pol_q, ack_dt_q, ack_en_q};
            `OFS_BUFFER: rdata_d = {24'h0, buffer_q};
            `OFS_STATUS: rdata_d = {29'h0, done_q, write_collision_flag_q, state_q != ST_IDLE};
            `OFS_BAUD: rdata_d = {24'h0, baud_q};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
      // sequencer
      unique case (state_q)
         ST_IDLE: begin
            sclk_d = pol_q; // clock stopped at idle level
            if (!hold_q) begin
               ss_n_d = `SELECT_NONE; // deselect once nothing more to send
            end
         end
         ST_SPI_LEAD: begin
            if (cnt_zero) begin
               sclk_d = ~pol_q;
               rx_bit_d = link.serial_in_pin; // capture on leading edge
               cnt_d = baud_q;
               state_d = ST_SPI_TRAIL;
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         ST_SPI_TRAIL: begin
            if (cnt_zero) begin
               sclk_d = pol_q;
               shift_d = {shift_q[6:0], rx_bit_q}; // msb out, lsb
               mosi_d = shift_q[6]; // drive on trailing edge
               bit_d = bit_q + 3'h1;
               cnt_d = baud_q;
               state_d = ST_SPI_LEAD;
               if (bit_q == `BITS_PER_BYTE) begin
                  buffer_d = {shift_q[6:0], rx_bit_q}; // exchange complete
                  done_set = 1'b1;
                  state_d = ST_IDLE; // clock stops here
               end
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         ST_ACK_LOW: begin
            if (cnt_zero) begin
               scl_oe_d = 1'b0; // release scl after one period
               state_d = ST_ACK_WAIT;
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         ST_ACK_WAIT: begin
            if (link.scl_level) begin
               cnt_d = baud_q; // stretching honoured, period restarts
               state_d = ST_ACK_HIGH;
            end
         end
         ST_ACK_HIGH: begin
            if (cnt_zero) begin
               scl_oe_d = 1'b1; // scl low again
               ack_en_d = 1'b0; // enable self-clears, counter stops
               state_d = ST_IDLE;
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         default: state_d = ST_IDLE;
      endcase
      // register writes
      if (wr) begin
         unique case (paddr)
            `OFS_CONTROL: begin
               ack_dt_d = pwdata[`CTL_ACK_DATA_BIT];
               hold_d = pwdata[`CTL_HOLD_BIT];
               if (state_q == ST_IDLE) begin
                  pol_d = pwdata[`CTL_POLARITY_BIT];
                  sidx_d = pwdata[`CTL_SLAVE_BIT];
                  if (pwdata[`CTL_ACK_EN_BIT]) begin
                     ack_en_d = 1'b1;
                     scl_oe_d = 1'b1; // scl low
                     sda_oe_d = ~pwdata[`CTL_ACK_DATA_BIT]; // ack bit on sda
                     cnt_d = baud_q;
                     state_d = ST_ACK_LOW;
                  end
               end
            end
            `OFS_BUFFER: begin
               if (state_q != ST_IDLE) begin
                  write_collision_flag_set = 1'b1; // buffer left unchanged
               end else begin
                  shift_d = pwdata[7:0]; // load and start a byte
                  mosi_d = pwdata[7]; // msb first
                  bit_d = 3'h0;
                  ss_n_d = sidx_q ? 2'b01 : 2'b10; // exactly one select low
                  sclk_d = pol_q;
                  cnt_d = baud_q;
                  state_d = ST_SPI_LEAD;
               end
            end
            `OFS_STATUS: begin
               // write one to clear
               if (pwdata[`STA_WRITE_COLLISION_FLAG_BIT]) begin
                  write_collision_flag_d = 1'b0;
               end
               if (pwdata[`STA_DONE_BIT]) begin
                  done_d = 1'b0;
               end
            end
            `OFS_BAUD: baud_d = pwdata[7:0];
            default: ;
         endcase
      end
      // set wins over a clear in the same cycle
      if (write_collision_flag_set) begin
         write_collision_flag_d = 1'b1;
      end
      if (done_set) begin
         done_d = 1'b1;
      end
   end

   // register all state
   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= ST_IDLE;
         baud_q <= `BAUD_RESET;
         cnt_q <= 8'h00;
         shift_q <= 8'h00;
         buffer_q <= 8'h00;
         bit_q <= 3'h0;
         rx_bit_q <= 1'b0;
         sclk_q <= 1'b0;
         mosi_q <= 1'b0;
         ss_n_q <= `SELECT_NONE;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         ack_en_q <= 1'b0;
         ack_dt_q <= 1'b0;
         pol_q <= 1'b0;
         hold_q <= 1'b0;
         sidx_q <= 1'b0;
         write_collision_flag_q <= 1'b0;
         done_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rdy_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         state_q <= state_d;
         baud_q <= baud_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         buffer_q <= buffer_d;
         bit_q <= bit_d;
         rx_bit_q <= rx_bit_d;
         sclk_q <= sclk_d;
         mosi_q <= mosi_d;
         ss_n_q <= ss_n_d;
         scl_oe_q <= scl_oe_d;
         sda_oe_q <= sda_oe_d;
         ack_en_q <= ack_en_d;
         ack_dt_q <= ack_dt_d;
         pol_q <= pol_d;
         hold_q <= hold_d;
         sidx_q <= sidx_d;
         write_collision_flag_q <= write_collision_flag_d;
         done_q <= done_d;
         rdata_q <= rdata_d;
         rdy_q <= rdy_d;
         err_q <= err_d;
      end
   end

   // outputs straight from flops
   assign prdata = rdata_q;
   assign pready = rdy_q;
   assign pslverr = err_q;
   assign link.serial_clock_pin = sclk_q;
   assign link.serial_out_pin = mosi_q;
   assign link.slave_select_pin_n = ss_n_q;
   assign link.dev_scl_oe = scl_oe_q;
   assign link.dev_sda_oe = sda_oe_q;
endmodule

// >>> verif/serial_link_monitor.sv
// concurrent checks on the serial link between port and far end
// assumes one clock, sync high reset, baud reload left at its reset value
`timescale 1ns/100ps
module serial_link_monitor (
   input wire logic clk,
   input wire logic reset,
   input wire logic serial_clock_pin,
   input wire logic serial_out_pin,
   input wire logic [1:0] slave_select_pin_n,
   input wire logic slave_out_oe,
   input wire logic dev_scl_oe,
   input wire logic dev_sda_oe,
   input wire logic scl_level
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // never two slaves selected
   property p_one_select;
      slave_select_pin_n != 2'b00;
   endproperty
   a_one_select: assert property (p_one_select) else $error("two selects low");

   // unselected slave leaves its data line
   property p_unselected_quiet;
      slave_select_pin_n[0] && $past(slave_select_pin_n[0]) |-> !slave_out_oe;
   endproperty
   a_unselected_quiet: assert property (p_unselected_quiet) else $error("unselected slave drives");

   // selected slave drives within two cycles
   property p_oe_on_select;
      $fell(slave_select_pin_n[0]) |-> ##[1:2] slave_out_oe;
   endproperty
   a_oe_on_select: assert property (p_oe_on_select) else $error("selected slave silent");

   // data out moves only while a slave is selected
   property p_data_selected;
      $changed(serial_out_pin) |-> slave_select_pin_n != 2'b11;
   endproperty
   a_data_selected: assert property (p_data_selected) else $error("data moved while deselected");

   // clock edges at least one half bit of five cycles apart
   property p_sclk_spacing;
      $changed(serial_clock_pin) |=> $stable(serial_clock_pin) [*4];
   endproperty
   a_sclk_spacing: assert property (p_sclk_spacing) else $error("clock half bit too short");

   // scl seen pulled low one, two and four cycles before release
   property p_ack_release;
      $fell(dev_scl_oe) |-> $past(dev_scl_oe, 4) && $past(dev_scl_oe, 2);
   endproperty
   a_ack_release: assert property (p_ack_release) else $error("scl released early");

   // high phase counted from scl seen high, then pulled low
   property p_ack_high_phase;
      $rose(scl_level) |=> scl_level [*3] ##[1:6] dev_scl_oe;
   endproperty
   a_ack_high_phase: assert property (p_ack_high_phase) else $error("scl high phase wrong");

   // ack bit stays put while scl is high
   property p_sda_stable;
      scl_level && $past(scl_level) |-> $stable(dev_sda_oe);
   endproperty
   a_sda_stable: assert property (p_sda_stable) else $error("sda moved under high scl");
endmodule

// >>> verif/tb.sv
// self-checking bench: apb master on the port, far end joined by the link
// assumes pready answers after setup and baud reload stays at 4
`timescale 1ns/100ps
module tb;
   logic clk = 1'b0; // 4 ns clock
   logic reset = 1'b1; // sync reset
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] far_tx = 8'h00; // byte the far end returns
   logic far_pol = 1'b0; // far end clock polarity
   logic stretch = 1'b0; // far end holds scl low
   logic [7:0] far_rx;
   logic far_rx_v;
   logic [7:0] far_ack;
   logic far_ack_v;
   logic [7:0] last_rx = 8'h00; // last byte seen by far end
   logic [7:0] last_ack = 8'h00; // last ack bit seen by far end
   int bad_count = 0;
   int checks = 0;

   serial_link_if link();
   sync_serial_port i_sync_serial_port (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link));
   serial_far_end #(.SELECT_INDEX(0)) i_serial_far_end (.clk(clk), .reset(reset), .link(link),
      .tx_byte(far_tx), .clock_polarity(far_pol), .stretch_hold(stretch), .rx_byte(far_rx),
      .rx_valid(far_rx_v), .ack_value(far_ack), .ack_valid(far_ack_v));
   serial_link_monitor i_serial_link_monitor (.clk(clk), .reset(reset),
      .serial_clock_pin(link.serial_clock_pin), .serial_out_pin(link.serial_out_pin),
      .slave_select_pin_n(link.slave_select_pin_n), .slave_out_oe(link.slave_out_oe),
      .dev_scl_oe(link.dev_scl_oe), .dev_sda_oe(link.dev_sda_oe), .scl_level(link.scl_level));

   // free-running clock
   always #2 clk = ~clk;

   // capture far end pulses
   always @(posedge clk) begin
      if (far_rx_v === 1'b1) last_rx <= far_rx;
      if (far_ack_v === 1'b1) last_ack <= far_ack;
   end

   // compare and count
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // verdict and end of run
   task conclude();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // one apb transfer: setup, access until pready
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
            output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(a, 1'b1, d, r, e);
   endtask

   task rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(a, 1'b0, 32'h0, r, e);
   endtask

   // poll a register bit until it clears, bounded
   task wait_clear(input logic [7:0] a, input int b);
      logic [31:0] r;
      for (int i = 0; i < 100; i++) begin
         rd(a, r);
         if (r[b] === 1'b0) break;
      end
   endtask

   // one byte exchange with checks on both ends
   task spi(input logic [7:0] m, input logic [7:0] exp_m, input logic [7:0] exp_f);
      logic [31:0] r;
      wr(8'h04, {24'h0, m});
      wait_clear(8'h08, 0);
      rd(8'h04, r);
      chk(r, {24'h0, exp_m});
      repeat (2) @(posedge clk);
      chk({24'h0, last_rx}, {24'h0, exp_f});
   endtask

   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      conclude();
   end

   initial begin
      logic [31:0] r;
      logic e;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      // reset values and unmapped access
      rd(8'h00, r);
      chk(r, 32'h0);
      rd(8'h08, r);
      chk(r, 32'h0);
      rd(8'h0c, r);
      chk(r, 32'h4);
      apb(8'h10, 1'b0, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      $display("test reset done");
      // both polarities, two bytes with select held
      for (int p = 0; p < 2; p++) begin
         far_pol <= p[0];
         far_tx <= 8'ha5 ^ p[7:0];
         wr(8'h00, 32'h8 | (p << 2));
         spi(8'h3c, 8'ha5 ^ p[7:0], 8'h3c);
         chk({30'h0, link.slave_select_pin_n}, 32'h2);
         spi(8'hc3 ^ p[7:0], 8'ha5 ^ p[7:0], 8'hc3 ^ p[7:0]);
         wr(8'h00, p << 2);
         repeat (3) @(posedge clk);
         chk({30'h0, link.slave_select_pin_n}, 32'h3);
         $display("test spi polarity %0d done", p);
      end
      // other slave selected: far end ignores, line idles high
      far_pol <= 1'b0;
      wr(8'h00, 32'h10);
      spi(8'h5a, 8'hff, 8'hc2);
      rd(8'h08, r);
      chk(r, 32'h4);
      wr(8'h08, 32'h4);
      rd(8'h08, r);
      chk(r, 32'h0);
      $display("test deselected slave done");
      // ack sequence with both bit values, stretch on the second
      for (int a = 0; a < 2; a++) begin
         stretch <= a[0];
         wr(8'h00, a << 1);
         wr(8'h00, (a << 1) | 1);
         // let the enable edge settle before looking at the line
         @(posedge clk);
         chk({31'h0, link.dev_sda_oe}, {31'h0, ~a[0]});
         wr(8'h04, 32'h77);
         rd(8'h08, r);
         chk({31'h0, r[1]}, 32'h1);
         if (a == 1) begin
            repeat (20) @(posedge clk);
            rd(8'h00, r);
            chk(r, 32'h3);
            stretch <= 1'b0;
         end
         wait_clear(8'h00, 0);
         rd(8'h00, r);
         chk(r, a << 1);
         chk({31'h0, last_ack[0]}, {31'h0, a[0]});
         chk({31'h0, link.dev_scl_oe}, 32'h1);
         rd(8'h04, r);
         chk(r, 32'hff);
         wr(8'h08, 32'h2);
         rd(8'h08, r);
         chk(r, 32'h0);
         $display("test ack %0d done", a);
      end
      conclude();
   end
endmodule
